//--- hw/backlight_ldo_control.sv
// Control logic of the light management unit: sink levels, fade sequencer, pump and regulator gating, faults.
// Assumes an AHB-Lite master on hclk and analog detectors that deliver clean levels on the sense inputs.
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/1ps

// Notes on behaviour
// - Sinks take one of 29 levels.
// - Half, one, two mA step bands.
// - Enable bit or zero level turns off.
// - Sinks start disabled after power-up.
// - Pump clock 250 kHz, stopped in 1x.
// - Pump mode automatic, hysteresis on descent.
// - Reduced bias at 4.0 mA or below.
// - Fade ramps through every level step.
// - Rate change applies to remaining steps.
// - New target redirects running ramp.
// - Fade disable jumps to final target.
// - Without fade, new level applies at once.
// - Regulators need one voltage write first.
// - Enable pin low forces regulator off.
// - Regulator codes in 100 mV steps.
// - Long low on link resets registers.
// - All sinks disabled means sleep.
// - Overvoltage stops pump until it drops.
// - Thermal shutdown disables outputs, keeps registers.
// - Open sink detected gets disabled.
module backlight_ldo_control #(
  parameter int shutdown_cycles  = lmu_pkg::SHUTDOWN_CYCLES,
  parameter int fade_base_cycles = lmu_pkg::FADE_BASE_CYCLES
) (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output wire logic            hreadyout,
  output wire logic [31:0]     hrdata,
  output wire logic            hresp,
  input  wire logic            single_wire_control_pin,
  input  wire logic            regulator_one_enable_pin,
  input  wire logic            regulator_two_enable_pin,
  input  wire lmu_pkg::sense_s sense,
  output wire lmu_pkg::drive_s drive
);

  lmu_pkg::state_s  st;
  lmu_pkg::state_s  next_st;
  lmu_pkg::async_s  in_lvl;
  localparam int CNT_W_L = lmu_pkg::CNT_W;
  logic [CNT_W_L-1:0] fade_period;

  // Maps a level code to sink current in half-milliamp units.
  // The three bands meet at codes 10 and 26, so the mapping stays monotonic across both joins.
  function automatic logic [5:0] half_ma(input logic [4:0] code);
    logic [6:0] top;
    top = {code, 2'b00} - lmu_pkg::TOP_OFFSET;
    if (code <= lmu_pkg::LVL_FINE_TOP) begin
      half_ma = {1'b0, code};
    end else if (code <= lmu_pkg::LVL_MID_TOP) begin
      half_ma = {code, 1'b0} - lmu_pkg::MID_OFFSET;
    end else begin
      half_ma = top[5:0];
    end
  endfunction

  assign in_lvl = lmu_pkg::async_s'(st.stab);
  assign fade_period = CNT_W_L'(fade_base_cycles) << st.fade_rate;

  // The bus never stalls, so every transfer completes in a single data phase.
  // The response is always OKAY: unmapped or odd-sized accesses are ignored, and such reads return zero.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st.rdata;

  // Next-state logic for synchronisers, registers, fade, pump and fault handling.
  always_comb begin
    logic [5:0]         wdat;
    logic               run;
    logic               wr_en;
    lmu_pkg::status_s   s;
    wdat  = hwdata[5:0];
    run   = 1'b0;
    wr_en = st.ph && st.wr && st.ok && !st.shut;
    s     = '0;
    next_st = st;

    // A pin level counts once the second and third stages agree.
    next_st.sync_a = lmu_pkg::ASYNC_W'({single_wire_control_pin, regulator_one_enable_pin,
                                        regulator_two_enable_pin, sense});
    next_st.sync_b = st.sync_a;
    next_st.sync_c = st.sync_b;
    next_st.stab   = ((st.sync_b ~^ st.sync_c) & st.sync_c) | ((st.sync_b ^ st.sync_c) & st.stab);

    // Register writes in the data phase.
    // Writes land at the close of the data phase and are dropped while shutdown holds the defaults.
    // Only the low six bits of the word carry a setting; the upper bits are ignored.
    if (wr_en) begin
      case (st.idx)
        lmu_pkg::IDX_CURRENT: begin
          next_st.code = (wdat > lmu_pkg::LVL_MAX_W) ? lmu_pkg::LVL_MAX : wdat[4:0];
          if (!st.fade_en) begin
            next_st.level = next_st.code;
          end else if (next_st.code != st.level) begin
            next_st.fs = lmu_pkg::FADE_RAMP;
          end
        end
        lmu_pkg::IDX_ENABLE: begin
          next_st.sink_en   = wdat[3:0];
          next_st.float_lat = st.float_lat & wdat[3:0];
        end
        lmu_pkg::IDX_REG_ONE: begin
          next_st.reg_one  = wdat[3:0];
          next_st.one_prog = 1'b1;
        end
        lmu_pkg::IDX_REG_TWO: begin
          next_st.reg_two  = wdat[2:0];
          next_st.two_prog = 1'b1;
        end
        lmu_pkg::IDX_FADE: begin
          next_st.fade_en   = wdat[lmu_pkg::FADE_EN_BIT];
          next_st.fade_rate = wdat[lmu_pkg::FADE_RATE_LSB +: 2];
        end
        default: begin
        end
      endcase
    end

    // Fade sequencer; the tick stalls in sleep because the internal clock is stopped there.
    // A rate write changes only the pace of a running ramp; the level and the target are kept.
    case (st.fs)
      lmu_pkg::FADE_IDLE: begin
        next_st.tick = '0;
      end
      lmu_pkg::FADE_RAMP: begin
        if (!next_st.fade_en) begin
          next_st.level = next_st.code;
          next_st.fs    = lmu_pkg::FADE_IDLE;
          next_st.tick  = '0;
        end else if (st.sink_en != '0) begin
          if (st.tick >= fade_period - 1'b1) begin
            next_st.tick = '0;
            if (st.level < next_st.code) begin
              next_st.level = st.level + 5'h01;
            end else if (st.level > next_st.code) begin
              next_st.level = st.level - 5'h01;
            end
            if (next_st.level == next_st.code) begin
              next_st.fs = lmu_pkg::FADE_IDLE;
            end
          end else begin
            next_st.tick = st.tick + 1'b1;
          end
        end
      end
      default: begin
        next_st.fs = lmu_pkg::FADE_IDLE;
      end
    endcase

    // Float faults latch per enabled sink; a detection beats a clearing write.
    // A clear only sticks once the detector is quiet; a write while it still reports is overridden.
    next_st.float_lat = next_st.float_lat | (in_lvl.sense.sink_float & st.sink_en);

    // Pump mode selection; climbing is immediate, descending waits out the hysteresis count.
    // Climbing at once answers a regulation shortfall before the LEDs dim; the slow descent trades a little
    // efficiency for freedom from mode hopping when the load sits near a threshold.
    if (st.sink_en == '0 || in_lvl.sense.hot || st.shut) begin
      next_st.mode = lmu_pkg::PUMP_1X;
      next_st.hyst = '0;
    end else if (in_lvl.sense.demand_up) begin
      next_st.hyst = '0;
      case (st.mode)
        lmu_pkg::PUMP_1X:  next_st.mode = lmu_pkg::PUMP_15X;
        lmu_pkg::PUMP_15X: next_st.mode = lmu_pkg::PUMP_2X;
        default:           next_st.mode = lmu_pkg::PUMP_2X;
      endcase
    end else if (in_lvl.sense.demand_low && st.mode != lmu_pkg::PUMP_1X) begin
      if (st.hyst == 9'(lmu_pkg::HYST_CYCLES - 1)) begin
        next_st.hyst = '0;
        next_st.mode = (st.mode == lmu_pkg::PUMP_2X) ? lmu_pkg::PUMP_15X : lmu_pkg::PUMP_1X;
      end else begin
        next_st.hyst = st.hyst + 9'h001;
      end
    end else begin
      next_st.hyst = '0;
    end

    // Pump switching clock: divider toggles at twice the pump rate while allowed to run.
    run = (next_st.mode != lmu_pkg::PUMP_1X) && !in_lvl.sense.overvoltage;
    if (run) begin
      if (st.div == 7'(lmu_pkg::PUMP_HALF - 1)) begin
        next_st.div      = '0;
        next_st.pump_clk = !st.pump_clk;
      end else begin
        next_st.div = st.div + 7'h01;
      end
    end else begin
      next_st.div      = '0;
      next_st.pump_clk = 1'b0;
    end

    // Shutdown detection: a long low on the link returns every register to default.
    // Just after reset the synchronised pin still reads low, so the counter starts early; it is far longer
    // than the few cycles the pin needs to pass the three stages, so reset causes no false shutdown.
    if (in_lvl.pin) begin
      next_st.sd_cnt = '0;
      next_st.shut   = 1'b0;
    end else if (!st.shut) begin
      if (st.sd_cnt == CNT_W_L'(shutdown_cycles - 1)) begin
        next_st.shut = 1'b1;
      end else begin
        next_st.sd_cnt = st.sd_cnt + 1'b1;
      end
    end
    if (next_st.shut) begin
      next_st.code      = '0;
      next_st.sink_en   = '0;
      next_st.reg_one   = '0;
      next_st.reg_two   = '0;
      next_st.fade_en   = 1'b0;
      next_st.fade_rate = '0;
      next_st.one_prog  = 1'b0;
      next_st.two_prog  = 1'b0;
      next_st.level     = '0;
      next_st.fs        = lmu_pkg::FADE_IDLE;
      next_st.float_lat = '0;
    end

    // Address phase capture; read data comes from the updated state so a read right after a write sees it.
    next_st.ph  = hsel && htrans[1] && hready;
    next_st.wr  = hwrite;
    next_st.idx = haddr[4:2];
    next_st.ok  = (haddr[31:5] == '0) && (haddr[4:2] <= lmu_pkg::IDX_STATUS) && (hsize == 3'h2);
    s.overvoltage   = in_lvl.sense.overvoltage;
    s.hot           = in_lvl.sense.hot;
    s.sleep         = (next_st.sink_en == '0);
    s.ramping       = (next_st.fs == lmu_pkg::FADE_RAMP);
    s.mode          = next_st.mode;
    s.float_latched = next_st.float_lat;
    s.level         = next_st.level;
    next_st.rdata = '0;
    if (next_st.ph && !hwrite && next_st.ok) begin
      case (next_st.idx)
        lmu_pkg::IDX_CURRENT: next_st.rdata = 32'(next_st.code);
        lmu_pkg::IDX_ENABLE:  next_st.rdata = 32'(next_st.sink_en);
        lmu_pkg::IDX_REG_ONE: next_st.rdata = 32'(next_st.reg_one);
        lmu_pkg::IDX_REG_TWO: next_st.rdata = 32'(next_st.reg_two);
        lmu_pkg::IDX_FADE:    next_st.rdata = 32'({next_st.fade_rate, next_st.fade_en});
        lmu_pkg::IDX_STATUS:  next_st.rdata = 32'(s);
        default:              next_st.rdata = '0;
      endcase
    end
  end

  // State register; the sinks come up off because every enable resets to zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Per-sink drive: on only with enable, a nonzero level and no fault or thermal shutdown.
  // Faults and a hot die gate the current here rather than in the registers, so the settings survive.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sink
      assign drive.sink_on[gi] = st.sink_en[gi] && (st.level != '0) && !st.float_lat[gi]
                                 && !in_lvl.sense.hot && !st.shut;
      assign drive.sink_half_ma[gi] = drive.sink_on[gi] ? half_ma(st.level) : 6'h00;
    end
  endgenerate

  // Pump, bias, mode and regulator controls; pins gate the regulators regardless of settings.
  assign drive.pump_mode  = st.mode;
  assign drive.pump_clk   = st.pump_clk;
  assign drive.low_bias   = (st.level <= lmu_pkg::LVL_LOWBIAS);
  assign drive.sleep      = (st.sink_en == '0);
  assign drive.shutdown   = st.shut;
  assign drive.reg_one_on = in_lvl.en_one && st.one_prog && !in_lvl.sense.hot && !st.shut;
  assign drive.reg_two_on = in_lvl.en_two && st.two_prog && !in_lvl.sense.hot && !st.shut;
  assign drive.reg_one_decivolt = lmu_pkg::REG_ONE_BASE + 6'(st.reg_one);
  assign drive.reg_two_decivolt = (lmu_pkg::REG_TWO_BASE + 6'(st.reg_two) > lmu_pkg::REG_TWO_TOP) ?
                                  lmu_pkg::REG_TWO_TOP : lmu_pkg::REG_TWO_BASE + 6'(st.reg_two);

  // Checks of the behaviour above.
  // The checks watch the synchronised copies of the asynchronous inputs, never those raw pins, so they see what the logic sees.
  // Every check is off during reset so that the cleared state is not judged against stale history.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  imm_apply_a: assert property (st.ph && st.wr && st.ok && !st.shut && st.idx == lmu_pkg::IDX_CURRENT
      && !st.fade_en && hwdata[5:0] <= lmu_pkg::LVL_MAX_W |=> st.level == $past(hwdata[4:0]))
    else $error("Level not applied at once without fade.");
  sink_gate_a: assert property (!st.sink_en[0] || st.level == '0 |-> !drive.sink_on[0]
      && drive.sink_half_ma[0] == 6'h00)
    else $error("Sink carries current while disabled.");
  low_bias_a: assert property (drive.low_bias == (half_ma(st.level) <= 6'h08))
    else $error("Bias state disagrees with level.");
  pump_stop_a: assert property (st.mode == lmu_pkg::PUMP_1X ##1 st.mode == lmu_pkg::PUMP_1X |-> !st.pump_clk)
    else $error("Pump clock running in 1x.");
  ramp_step_a: assert property (st.fs == lmu_pkg::FADE_RAMP ##1 st.fade_en && !st.shut |->
      st.level == $past(st.level) || st.level == $past(st.level) + 5'h01 || st.level + 5'h01 == $past(st.level))
    else $error("Fade moved more than one step.");
  fade_cancel_a: assert property (st.fs == lmu_pkg::FADE_RAMP && st.ph && st.wr && st.ok && !st.shut
      && st.idx == lmu_pkg::IDX_FADE && !hwdata[lmu_pkg::FADE_EN_BIT] |=> st.level == $past(st.code) || st.shut)
    else $error("Cancel did not jump to target.");
  reg_pin_a: assert property (!in_lvl.en_one || !st.one_prog |-> !drive.reg_one_on)
    else $error("Regulator one on without pin or setting.");
  thermal_off_a: assert property (in_lvl.sense.hot |-> drive.sink_on == '0 && !drive.reg_two_on)
    else $error("Outputs active in thermal shutdown.");
  shut_reset_a: assert property (st.shut |-> st.sink_en == '0 && st.code == '0 && !st.one_prog)
    else $error("Registers kept through shutdown.");
  ovp_stop_a: assert property (in_lvl.sense.overvoltage |=> !st.pump_clk)
    else $error("Pump switching during overvoltage.");
  code_sat_a: assert property (st.code <= lmu_pkg::LVL_MAX && st.level <= lmu_pkg::LVL_MAX)
    else $error("Level code above top of scale.");
  float_off_a: assert property (st.float_lat[1] |-> !drive.sink_on[1])
    else $error("Floating sink still on.");
  reg_two_pin_a: assert property (!in_lvl.en_two || !st.two_prog |-> !drive.reg_two_on)
    else $error("Regulator two on without pin or setting.");
  sleep_pump_a: assert property (drive.sleep |=> st.mode == lmu_pkg::PUMP_1X && !st.pump_clk)
    else $error("Pump active in sleep.");
  hot_pump_a: assert property (in_lvl.sense.hot |=> st.mode == lmu_pkg::PUMP_1X && !st.pump_clk)
    else $error("Pump running in thermal shutdown.");

  ramp_done_c: cover property (st.fs == lmu_pkg::FADE_RAMP ##1 st.fs == lmu_pkg::FADE_IDLE);
  mode_two_c: cover property (st.mode == lmu_pkg::PUMP_2X);
  shutdown_c: cover property ($rose(st.shut));
  float_c: cover property ($rose(st.float_lat[2]));
  redirect_c: cover property (st.fs == lmu_pkg::FADE_RAMP && st.ph && st.wr && st.ok && st.idx == lmu_pkg::IDX_CURRENT);

endmodule // backlight_ldo_control

//--- pkg/lmu_pkg.sv
// Constants, register indices and carrier types for the light management control block.
// Assumes a 25 MHz bus clock and a single AHB-Lite master with word-only transfers.
package lmu_pkg;

  // Clock and timing figures; cycle counts derive from the printed times.
  localparam int CLK_HZ           = 25_000_000;
  localparam int PUMP_HZ          = 250_000;
  localparam int PUMP_HALF        = CLK_HZ / (2 * PUMP_HZ);
  localparam int SHUTDOWN_MS      = 10;
  localparam int SHUTDOWN_CYCLES  = SHUTDOWN_MS * (CLK_HZ / 1000);
  localparam int FADE_BASE_US     = 1000;
  localparam int FADE_BASE_CYCLES = FADE_BASE_US * (CLK_HZ / 1_000_000);
  localparam int HYST_US          = 20;
  localparam int HYST_CYCLES      = HYST_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W            = 18;

  // Register indices; the byte address is four times the index.
  localparam logic [2:0] IDX_CURRENT = 3'h0;
  localparam logic [2:0] IDX_ENABLE  = 3'h1;
  localparam logic [2:0] IDX_REG_ONE = 3'h2;
  localparam logic [2:0] IDX_REG_TWO = 3'h3;
  localparam logic [2:0] IDX_FADE    = 3'h4;
  localparam logic [2:0] IDX_STATUS  = 3'h5;

  // Field positions and level scale points.
  localparam int FADE_EN_BIT    = 0;
  localparam int FADE_RATE_LSB  = 1;
  localparam logic [5:0] LVL_MAX_W   = 6'h1C;
  localparam logic [4:0] LVL_MAX     = 5'h1C;
  localparam logic [4:0] LVL_FINE_TOP = 5'h0A;
  localparam logic [4:0] LVL_MID_TOP = 5'h1A;
  localparam logic [4:0] LVL_LOWBIAS = 5'h08;
  localparam logic [5:0] MID_OFFSET  = 6'h0A;
  localparam logic [6:0] TOP_OFFSET  = 7'h3E;
  localparam logic [5:0] REG_ONE_BASE = 6'h0F;
  localparam logic [5:0] REG_TWO_BASE = 6'h0C;
  localparam logic [5:0] REG_TWO_TOP  = 6'h12;

  typedef enum logic [1:0] {PUMP_1X, PUMP_15X, PUMP_2X} pump_e;
  typedef enum logic {FADE_IDLE, FADE_RAMP} fade_e;

  // Analog comparator and detector levels arriving from outside the clock domain.
  typedef struct packed {
    logic       overvoltage;
    logic       hot;
    logic       demand_up;
    logic       demand_low;
    logic [3:0] sink_float;
  } sense_s;

  // All asynchronous inputs, synchronised together.
  typedef struct packed {
    logic   pin;
    logic   en_one;
    logic   en_two;
    sense_s sense;
  } async_s;

  localparam int ASYNC_W = $bits(async_s);

  // Controls sent to the analog sinks, pump and regulators.
  typedef struct packed {
    logic [3:0][5:0] sink_half_ma;
    logic [3:0]      sink_on;
    pump_e           pump_mode;
    logic            pump_clk;
    logic            low_bias;
    logic            sleep;
    logic            shutdown;
    logic            reg_one_on;
    logic            reg_two_on;
    logic [5:0]      reg_one_decivolt;
    logic [5:0]      reg_two_decivolt;
  } drive_s;

  // Read-only status word layout.
  typedef struct packed {
    logic       overvoltage;
    logic       hot;
    logic       sleep;
    logic       ramping;
    pump_e      mode;
    logic [3:0] float_latched;
    logic [4:0] level;
  } status_s;

  // Whole state of the control block.
  typedef struct packed {
    logic [ASYNC_W-1:0] sync_a;
    logic [ASYNC_W-1:0] sync_b;
    logic [ASYNC_W-1:0] sync_c;
    logic [ASYNC_W-1:0] stab;
    logic               ph;
    logic               wr;
    logic               ok;
    logic [2:0]         idx;
    logic [31:0]        rdata;
    logic [4:0]         code;
    logic [3:0]         sink_en;
    logic [3:0]         reg_one;
    logic [2:0]         reg_two;
    logic               fade_en;
    logic [1:0]         fade_rate;
    logic               one_prog;
    logic               two_prog;
    logic [4:0]         level;
    fade_e              fs;
    logic [CNT_W-1:0]   tick;
    logic [CNT_W-1:0]   sd_cnt;
    logic               shut;
    logic [3:0]         float_lat;
    pump_e              mode;
    logic [8:0]         hyst;
    logic [6:0]         div;
    logic               pump_clk;
  } state_s;

endpackage

//--- testbench/host_link_model.sv
// Host model on the single-wire link: it keeps the pin high, and on request holds it low long enough to shut down.
// Assumes the bench raises shut_req once for each shutdown and drops it before it asks again.
`timescale 1ns/1ps
module host_link_model #(
  parameter int shutdown_cycles = 20
) (
  input  wire logic hclk,
  input  wire logic shut_req,
  output wire logic single_wire_control_pin
);
  int   low_left = 0;
  logic req_q    = 1'b0;

  // A low hold of the full shutdown time plus margin, so that a slow synchroniser cannot cut it short.
  always @(posedge hclk) begin
    req_q <= shut_req;
    if (shut_req && !req_q) begin
      low_left <= shutdown_cycles + 10;
    end else if (low_left > 0) begin
      low_left <= low_left - 1;
    end
  end

  // The pin idles high between commands, which keeps the device enabled.
  assign single_wire_control_pin = (low_left == 0);
endmodule // host_link_model

//--- testbench/test_backlight_ldo_control.sv
// Self-checking bench for the light control block: AHB-Lite register tasks and directed scenarios.
// Assumes the block answers with no wait states and that the sense inputs are clean levels.
`timescale 1ns/1ps
module test_backlight_ldo_control;
  logic            hclk     = 1'b0;
  logic            hresetn  = 1'b0;
  logic            hsel     = 1'b0;
  logic [31:0]     haddr    = 32'h0;
  logic [1:0]      htrans   = 2'h0;
  logic            hwrite   = 1'b0;
  logic [31:0]     hwdata   = 32'h0;
  logic            en_one   = 1'b0;
  logic            en_two   = 1'b0;
  logic            shut_req = 1'b0;
  lmu_pkg::sense_s sense    = '0;
  wire             hreadyout;
  wire  [31:0]     hrdata;
  wire             hresp;
  wire             pin;
  lmu_pkg::drive_s drive;
  logic [31:0]     rd_q, q;
  int              miscompares = 0, checks_done = 0, mlvl = 0, gap = 0, last_gap = 0, code, hi;
  logic            mon_on = 1'b0;
  logic            up;

  // Half period of 20 ns gives the 25 MHz bus clock.
  always #20 hclk = ~hclk;

  // Read data are taken at the edge that closes the data phase.
  always @(posedge hclk) rd_q <= hrdata;

  backlight_ldo_control #(.shutdown_cycles(20), .fade_base_cycles(4)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .single_wire_control_pin(pin), .regulator_one_enable_pin(en_one), .regulator_two_enable_pin(en_two),
    .sense(sense), .drive(drive));

  host_link_model #(.shutdown_cycles(20)) host (.hclk(hclk), .shut_req(shut_req), .single_wire_control_pin(pin));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One single transfer; the address phase is held until hready is seen high, then the data phase likewise.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= a;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    #1 r = rd_q;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(r, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge hclk);
  endtask

  function automatic logic [31:0] ad(input logic [2:0] i);
    return {27'h0, i, 2'h0};
  endfunction

  // Sink current in 0.5 mA units: fine band to 5 mA, 1 mA band to 21 mA, 2 mA band to 25 mA.
  function automatic logic [5:0] half(input int c);
    c = (c > 28) ? 28 : c;
    return (c <= 10) ? c : (c <= 26) ? 2 * c - 10 : 4 * c - 62;
  endfunction

  task automatic reach(input int t);
    for (int n = 0; n < 400 && mlvl != t; n++) @(negedge hclk);
    check(mlvl, t);
  endtask

  // Pump clock half period, measured from a clean rising edge.
  task automatic clk_half();
    int n;
    for (n = 0; n < 200 && drive.pump_clk !== 1'b0; n++) @(negedge hclk);
    for (n = 0; n < 200 && drive.pump_clk !== 1'b1; n++) @(negedge hclk);
    for (n = 0; n < 200 && drive.pump_clk === 1'b1; n++) @(negedge hclk);
    check(n, lmu_pkg::PUMP_HALF);
  endtask

  // While a ramp runs, every change of the sink must be one scale step up or down.
  always @(negedge hclk) begin
    if (mon_on) begin
      gap++;
      if (drive.sink_half_ma[0] !== half(mlvl)) begin
        up = (drive.sink_half_ma[0] === half(mlvl + 1));
        check(drive.sink_half_ma[0], up ? half(mlvl + 1) : half(mlvl - 1));
        mlvl = up ? mlvl + 1 : mlvl - 1;
        last_gap = gap;
        gap = 0;
      end
    end
  end

  // A hang ends the run well past the expected length of about two thousand two hundred cycles.
  initial begin
    #2000000;
    miscompares++;
    report_and_stop();
  end

  // Main sequence; sense and pin inputs need several cycles to pass the synchronisers.
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    tick(1);
    check(drive.sleep, 1'b1);
    check(drive.sink_half_ma, 24'h0);
    check(drive.pump_clk, 1'b0);
    @(posedge hclk);
    en_one <= 1'b1;
    en_two <= 1'b1;
    tick(8);
    check(drive.reg_one_on, 1'b0);
    wr(ad(lmu_pkg::IDX_REG_ONE), 32'h3);
    wr(ad(lmu_pkg::IDX_REG_TWO), 32'h7);
    tick(2);
    check(drive.reg_one_on, 1'b1);
    check(drive.reg_one_decivolt, 6'h12);
    check(drive.reg_two_decivolt, 6'h12);
    wr(ad(lmu_pkg::IDX_REG_TWO), 32'h2);
    rd_chk(ad(lmu_pkg::IDX_REG_ONE), 32'h3);
    check(drive.reg_two_decivolt, 6'h0E);
    @(posedge hclk);
    en_one <= 1'b0;
    tick(8);
    check(drive.reg_one_on, 1'b0);
    check(drive.reg_two_on, 1'b1);
    wr(ad(lmu_pkg::IDX_ENABLE), 32'h5);
    for (int c = 0; c < 31; c++) begin
      code = (c < 29) ? c : (c == 29) ? 29 : 63;
      wr(ad(lmu_pkg::IDX_CURRENT), code);
      tick(2);
      check(drive.sink_half_ma[0], half(code));
      check(drive.sink_half_ma[1], 6'h0);
      check(drive.sink_on, (code != 0) ? 4'h5 : 4'h0);
      check(drive.sleep, 1'b0);
      if (code != 0)
        check(drive.low_bias, half(code) <= 6'h08);
      rd_chk(ad(lmu_pkg::IDX_CURRENT), (code > 28) ? 28 : code);
    end
    @(posedge hclk);
    sense.demand_up <= 1'b1;
    tick(8);
    check(drive.pump_mode, lmu_pkg::PUMP_2X);
    clk_half();
    @(posedge hclk);
    sense.overvoltage <= 1'b1;
    tick(8);
    hi = 0;
    repeat (60) begin
      @(negedge hclk);
      hi += (drive.pump_clk !== 1'b0);
    end
    check(hi, 0);
    @(posedge hclk);
    sense.overvoltage <= 1'b0;
    clk_half();
    @(posedge hclk);
    sense.demand_up  <= 1'b0;
    sense.demand_low <= 1'b1;
    tick(400);
    check(drive.pump_mode, lmu_pkg::PUMP_2X);
    tick(800);
    check(drive.pump_mode, lmu_pkg::PUMP_1X);
    check(drive.pump_clk, 1'b0);
    wr(ad(lmu_pkg::IDX_ENABLE), 32'h0);
    tick(2);
    check(drive.sink_on, 4'h0);
    check(drive.sleep, 1'b1);
    wr(ad(lmu_pkg::IDX_ENABLE), 32'h1);
    wr(ad(lmu_pkg::IDX_CURRENT), 32'h0);
    wr(ad(lmu_pkg::IDX_FADE), 32'h1);
    tick(2);
    mon_on = 1'b1;
    wr(ad(lmu_pkg::IDX_CURRENT), 32'h5);
    reach(5);
    check(last_gap, 4);
    wr(ad(lmu_pkg::IDX_CURRENT), 32'h14);
    reach(7);
    wr(ad(lmu_pkg::IDX_FADE), 32'h5);
    reach(20);
    check(last_gap, 16);
    wr(ad(lmu_pkg::IDX_FADE), 32'h1);
    wr(ad(lmu_pkg::IDX_CURRENT), 32'h0);
    reach(17);
    wr(ad(lmu_pkg::IDX_CURRENT), 32'h19);
    reach(25);
    wr(ad(lmu_pkg::IDX_CURRENT), 32'h2);
    reach(22);
    mon_on = 1'b0;
    wr(ad(lmu_pkg::IDX_FADE), 32'h0);
    tick(2);
    check(drive.sink_half_ma[0], 6'h02);
    bus(1'b0, ad(lmu_pkg::IDX_STATUS), 32'h0, q);
    check(q[11:0], 12'h002);
    wr(ad(lmu_pkg::IDX_ENABLE), 32'h5);
    wr(ad(lmu_pkg::IDX_CURRENT), 32'hA);
    @(posedge hclk);
    sense.sink_float <= 4'h6;
    tick(8);
    check(drive.sink_on, 4'h1);
    bus(1'b0, ad(lmu_pkg::IDX_STATUS), 32'h0, q);
    check(q[8:5], 4'h4);
    @(posedge hclk);
    sense.sink_float <= 4'h0;
    tick(8);
    wr(ad(lmu_pkg::IDX_ENABLE), 32'h1);
    wr(ad(lmu_pkg::IDX_ENABLE), 32'h5);
    tick(8);
    check(drive.sink_on, 4'h5);
    @(posedge hclk);
    en_one    <= 1'b1;
    sense.hot <= 1'b1;
    tick(8);
    check(drive.sink_on, 4'h0);
    check(drive.reg_one_on, 1'b0);
    @(posedge hclk);
    sense.hot <= 1'b0;
    tick(8);
    check(drive.sink_on, 4'h5);
    check(drive.reg_one_on, 1'b1);
    rd_chk(ad(lmu_pkg::IDX_CURRENT), 32'hA);
    @(posedge hclk);
    shut_req <= 1'b1;
    tick(28);
    check(drive.shutdown, 1'b1);
    check(drive.sink_on, 4'h0);
    @(posedge hclk);
    shut_req <= 1'b0;
    tick(25);
    check(drive.shutdown, 1'b0);
    rd_chk(ad(lmu_pkg::IDX_CURRENT), 32'h0);
    rd_chk(ad(lmu_pkg::IDX_ENABLE), 32'h0);
    check(drive.reg_one_on, 1'b0);
    wr(32'h18, 32'h3F);
    rd_chk(32'h18, 32'h0);
    report_and_stop();
  end
endmodule // test_backlight_ldo_control
